// [verilog/cfg_port_regs.vh]
// constants for the configuration-space control port
// assumes inclusion by the port logic and the internal register bank
`ifndef CFG_PORT_REGS_VH
`define CFG_PORT_REGS_VH

// ***************************
// configuration-space offsets
// ***************************
`define OFS_CONNECT_CMD 8'h00
`define OFS_CONNECT_STATUS 8'h04
`define OFS_DATA 8'h08
`define OFS_STATUS 8'h0C

// ***************************
// field positions
// ***************************
`define BIT_CONNECT 0
`define BIT_SEND_FULL 0
`define BIT_DATA_VALID 1
`define BIT_HDR_CMD 7
`define HDR_COUNT_MSB 6

// ***************************
// reset values and codes
// ***************************
`define RST_WORD 32'h0000_0000
`define RST_COUNT 7'h00
`define RST_BYTE 8'h00
`define CMD_WRITE 1'b1
`define STATUS_OK 8'h00
`define STATUS_FUNC_ERR 8'h01
`define COUNT_ONE 7'h01

// ***************************
// internal register numbers
// ***************************
`define IREG_DUMMY 8'h00
`define IREG_SCRATCH 8'h01
`define IREG_BLOCKS 8'h02
`define BLOCKS_ONE 16'h0001
`define RST_BLOCKS 16'h0000

`endif

// [verilog/card_reg_bank.v]
// internal card registers reached through the data register
// assumes the port logic hands it one selected register number at a time
`timescale 1ns/1ps
`default_nettype none
`include "cfg_port_regs.vh"

module card_reg_bank (
   // clock and reset
   input wire core_clk,
   input wire rst,
   input wire ce,
   // access from the transfer engine
   input wire [7:0] sel,
   input wire wr,
   input wire [31:0] wdata,
   input wire block_done,
   output reg [31:0] rdata,
   output reg bad_write,
   output reg bad_read
);

   reg [31:0] dummy_reg;
   reg [31:0] scratch_reg;
   reg [15:0] blocks_reg;

   // ***************************
   // storage
   // ***************************
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dummy_reg <= `RST_WORD;
         scratch_reg <= `RST_WORD;
         blocks_reg <= `RST_BLOCKS;
      end else if (ce) begin
         if (wr && sel == `IREG_DUMMY) begin
            dummy_reg <= wdata;
         end
         if (wr && sel == `IREG_SCRATCH) begin
            scratch_reg <= wdata;
         end
         if (block_done) begin
            blocks_reg <= blocks_reg + `BLOCKS_ONE;
         end
      end
   end

   // ***************************
   // decode
   // ***************************
   always @* begin
      rdata = `RST_WORD;
      bad_write = 1'b0;
      bad_read = 1'b0;
      case (sel)
         `IREG_DUMMY: rdata = dummy_reg;
         `IREG_SCRATCH: rdata = scratch_reg;
         `IREG_BLOCKS: begin
            rdata = {16'h0000, blocks_reg};
            bad_write = 1'b1; // counter is read-only
         end
         default: begin
            bad_write = 1'b1;
            bad_read = 1'b1;
         end
      endcase
   end

endmodule // card_reg_bank

`default_nettype wire

// [verilog/cfg_space_port.v]
// configuration-space control port: connect handshake, data and status registers
// assumes host config cycles arrive as synchronous strobes with byte enables
// Function
// - card sets acknowledge on accepted connect, clears it on withdrawal.
// - exactly one data register and one handshake status register.
// - data register is 32 bits, accessed byte, word or dword.
// - status shows room for another write and data ready to read.
// - register number written to data register selects, not payload.
// - every internal access goes through the same data register.
// - card returns a status value after every block.
// - a dummy internal register accepts writes for path checks.
// - header byte: count in bits 6:0, bit 7 write command.
// - host writes data only when send-full clear; card clears send-full the next cycle in every state.
// - host reads data after valid set, clears valid by writing one.
// - status byte is zero on success, non-zero on functional error.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_port_regs.vh"

module cfg_space_port (
   // clock and reset
   input wire core_clk,
   input wire rst,
   input wire ce,
   // configuration access port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire [3:0] byte_en,
   input wire wr_stb,
   input wire rd_stb,
   output reg [31:0] rdata
);

   // ***************************
   // engine states
   // ***************************
   localparam [2:0] ST_HEADER = 3'h0;
   localparam [2:0] ST_REGNO = 3'h1;
   localparam [2:0] ST_WRITE = 3'h2;
   localparam [2:0] ST_RD_LOAD = 3'h3;
   localparam [2:0] ST_RD_WAIT = 3'h4;
   localparam [2:0] ST_STAT_LOAD = 3'h5;
   localparam [2:0] ST_STAT_WAIT = 3'h6;

   reg connect_cmd_reg;
   reg ack_reg;
   reg send_full_reg;
   reg data_valid_reg;
   reg [31:0] data_in_reg;
   reg [31:0] data_out_reg;
   reg [2:0] state_reg;
   reg [6:0] count_reg;
   reg hdr_write_reg;
   reg [7:0] sel_reg;
   reg err_reg;

   wire [31:0] lane_mask;
   wire [31:0] masked_wdata;
   wire [31:0] bank_rdata;
   wire bank_bad_write;
   wire bank_bad_read;
   wire wr_data;
   wire wr_status;
   wire consume;
   wire bank_wr;
   wire block_done;
   wire valid_set;
   wire valid_clr;

   // ***************************
   // bus decode
   // ***************************
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_lane
         assign lane_mask[8*g+7:8*g] = {8{byte_en[g]}};
      end
   endgenerate

   assign masked_wdata = wdata & lane_mask;
   assign wr_data = wr_stb && addr == `OFS_DATA && ack_reg && !send_full_reg;
   assign wr_status = wr_stb && addr == `OFS_STATUS && byte_en[0];
   assign consume = send_full_reg && ack_reg;
   assign bank_wr = consume && state_reg == ST_WRITE && !bank_bad_write;
   assign block_done = state_reg == ST_STAT_WAIT && valid_clr;
   assign valid_set = state_reg == ST_RD_LOAD || state_reg == ST_STAT_LOAD;
   assign valid_clr = wr_status && wdata[`BIT_DATA_VALID];

   // ***************************
   // connection handshake
   // ***************************
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         connect_cmd_reg <= 1'b0;
         ack_reg <= 1'b0;
      end else if (ce) begin
         if (wr_stb && addr == `OFS_CONNECT_CMD && byte_en[0]) begin
            connect_cmd_reg <= wdata[`BIT_CONNECT];
         end
         // one cycle to accept or withdraw, leaves host polling room
         ack_reg <= connect_cmd_reg;
      end
   end

   // ***************************
   // data and status flags
   // ***************************
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         send_full_reg <= 1'b0;
         data_valid_reg <= 1'b0;
         data_in_reg <= `RST_WORD;
      end else if (ce) begin
         if (!ack_reg) begin
            send_full_reg <= 1'b0;
            data_valid_reg <= 1'b0;
         end else begin
            if (wr_data) begin
               data_in_reg <= masked_wdata;
               send_full_reg <= 1'b1;
            end else if (consume) begin
               send_full_reg <= 1'b0;
            end
            // set wins over a clear landing in the same cycle
            if (valid_set) begin
               data_valid_reg <= 1'b1;
            end else if (valid_clr) begin
               data_valid_reg <= 1'b0;
            end
         end
      end
   end

   // ***************************
   // block transfer engine
   // ***************************
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_HEADER;
         count_reg <= `RST_COUNT;
         hdr_write_reg <= 1'b0;
         sel_reg <= `RST_BYTE;
         err_reg <= 1'b0;
         data_out_reg <= `RST_WORD;
      end else if (ce) begin
         if (!ack_reg) begin
            // a withdrawn session abandons any block in flight
            state_reg <= ST_HEADER;
         end else begin
            case (state_reg)
               ST_HEADER: begin
                  if (consume) begin
                     count_reg <= data_in_reg[`HDR_COUNT_MSB:0];
                     hdr_write_reg <= data_in_reg[`BIT_HDR_CMD] == `CMD_WRITE;
                     err_reg <= 1'b0;
                     state_reg <= ST_REGNO;
                  end
               end
               ST_REGNO: begin
                  if (consume) begin
                     sel_reg <= data_in_reg[7:0];
                     if (count_reg == `RST_COUNT) begin
                        state_reg <= ST_STAT_LOAD;
                     end else if (hdr_write_reg) begin
                        state_reg <= ST_WRITE;
                     end else begin
                        state_reg <= ST_RD_LOAD;
                     end
                  end
               end
               ST_WRITE: begin
                  if (consume) begin
                     if (bank_bad_write) begin
                        err_reg <= 1'b1;
                     end
                     count_reg <= count_reg - `COUNT_ONE;
                     if (count_reg == `COUNT_ONE) begin
                        state_reg <= ST_STAT_LOAD;
                     end
                  end
               end
               ST_RD_LOAD: begin
                  data_out_reg <= bank_rdata;
                  if (bank_bad_read) begin
                     err_reg <= 1'b1;
                  end
                  state_reg <= ST_RD_WAIT;
               end
               ST_RD_WAIT: begin
                  if (valid_clr) begin
                     count_reg <= count_reg - `COUNT_ONE;
                     if (count_reg == `COUNT_ONE) begin
                        state_reg <= ST_STAT_LOAD;
                     end else begin
                        state_reg <= ST_RD_LOAD;
                     end
                  end
               end
               ST_STAT_LOAD: begin
                  data_out_reg <= {24'h000000, err_reg ? `STATUS_FUNC_ERR : `STATUS_OK};
                  state_reg <= ST_STAT_WAIT;
               end
               ST_STAT_WAIT: begin
                  if (valid_clr) begin
                     state_reg <= ST_HEADER;
                  end
               end
               default: state_reg <= ST_HEADER;
            endcase
         end
      end
   end

   // ***************************
   // read-back
   // ***************************
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata <= `RST_WORD;
      end else if (ce) begin
         rdata <= `RST_WORD;
         if (rd_stb) begin
            case (addr)
               `OFS_CONNECT_CMD: rdata <= {31'h0, connect_cmd_reg};
               `OFS_CONNECT_STATUS: rdata <= {31'h0, ack_reg};
               `OFS_DATA: rdata <= data_out_reg;
               `OFS_STATUS: rdata <= {30'h0, data_valid_reg, send_full_reg};
               default: rdata <= `RST_WORD;
            endcase
         end
      end
   end

   // ***************************
   // internal registers
   // ***************************
   card_reg_bank u_bank (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .sel(sel_reg),
      .wr(bank_wr),
      .wdata(data_in_reg),
      .block_done(block_done),
      .rdata(bank_rdata),
      .bad_write(bank_bad_write),
      .bad_read(bank_bad_read)
   );

endmodule // cfg_space_port

`default_nettype wire

// [dv/cfg_port_properties.sv]
// assertions on the config-space control port pins
// assumes a bind onto cfg_space_port
`timescale 1ns/1ps
`default_nettype none
`include "cfg_port_regs.vh"
module cfg_port_props (
   // clock and reset
   input wire core_clk,
   input wire rst,
   input wire ce,
   // config port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire [3:0] byte_en,
   input wire wr_stb,
   input wire rd_stb,
   input wire [31:0] rdata
);
   // ********
   // checks
   // ********
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   wire rg = rd_stb && ce;
   wire cw = wr_stb && ce && addr == `OFS_CONNECT_CMD && byte_en[0];
   wire rs = rg && addr == `OFS_STATUS;
   wire rc = rg && addr == `OFS_CONNECT_STATUS;
   idle_zero_a: assert property ($past(ce) && !$past(rd_stb) |-> rdata == 32'h0)
      else $error("rdata not idle");
   ack_set_a: assert property (cw && wdata[0] ##1 (!wr_stb)[*3] ##1 rc |=> rdata[0] == 1'b1)
      else $error("ack missing");
   ack_clear_a: assert property (cw && !wdata[0] ##1 (!wr_stb)[*3] ##1 rc |=> !rdata[0])
      else $error("ack stuck");
   abort_clear_a: assert property (cw && !wdata[0] ##1 (!wr_stb)[*3] ##1 rs
      |=> rdata[1:0] == 2'h0) else $error("flags kept after disconnect");
   // send-full may only follow a data write taken one edge before
   full_pulse_a: assert property (rs && $past(ce) && !$past(wr_stb && addr == `OFS_DATA)
      |=> !rdata[`BIT_SEND_FULL]) else $error("send-full stuck");
   status_fmt_a: assert property (rs |=> rdata[31:2] == 30'h0)
      else $error("status spare bits set");
   conn_fmt_a: assert property (rc |=> rdata[31:1] == 31'h0)
      else $error("connect status spare bits set");
   unmapped_a: assert property (rg && addr > `OFS_STATUS |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   cover property (cw && wdata[0]);
   cover property (rg && addr == `OFS_DATA);
   cover property (wr_stb && addr == `OFS_STATUS && wdata[1]);
endmodule // cfg_port_props
bind cfg_space_port cfg_port_props i_props (.core_clk, .rst, .ce, .addr, .wdata, .byte_en,
   .wr_stb, .rd_stb, .rdata);
`default_nettype wire

// [dv/cfg_host.sv]
// host model issuing config reads and writes
// assumes the card answers reads one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "cfg_port_regs.vh"
module cfg_host (
   // clock
   input wire core_clk,
   // config port
   output logic [7:0] addr,
   output logic [31:0] wdata,
   output logic [3:0] byte_en,
   output logic wr_stb,
   output logic rd_stb,
   input wire [31:0] rdata
);
   // ********
   // bus cycles
   // ********
   initial begin
      addr = 8'h00;
      wdata = 32'h0;
      byte_en = 4'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      byte_en <= be;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
      // stale data inverted so a late sample shows
      wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // polls are bounded; a stuck card shows as a wrong final value
   task automatic conn(input logic on, output logic [31:0] st);
      wr(`OFS_CONNECT_CMD, {31'h0, on}, 4'hF);
      idle(2);
      for (int i = 0; i < 50; i++) begin
         rd(`OFS_CONNECT_STATUS, st);
         if (st[`BIT_CONNECT] === on) break;
      end
   endtask
   task automatic send(input logic [31:0] d, input logic [3:0] be);
      logic [31:0] s;
      for (int i = 0; i < 50; i++) begin
         rd(`OFS_STATUS, s);
         if (s[`BIT_SEND_FULL] === 1'b0) break;
      end
      wr(`OFS_DATA, d, be);
   endtask
   task automatic take(output logic [31:0] d);
      logic [31:0] s;
      for (int i = 0; i < 50; i++) begin
         rd(`OFS_STATUS, s);
         if (s[`BIT_DATA_VALID] === 1'b1) break;
      end
      rd(`OFS_DATA, d);
      // a flag that never came must not pass for data
      if (s[`BIT_DATA_VALID] !== 1'b1) d = 32'hX;
      wr(`OFS_STATUS, 32'h2, 4'h1);
   endtask
endmodule // cfg_host
`default_nettype wire

// [dv/config_space_control_port_test.sv]
// self-checking bench for the config-space control port
// assumes host model and bound checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cfg_port_regs.vh"
module config_space_control_port_test;
   logic core_clk;
   logic rst;
   logic ce;
   wire [7:0] addr;
   wire [31:0] wdata;
   wire [31:0] rdata;
   wire [3:0] byte_en;
   wire wr_stb;
   wire rd_stb;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [31:0] v;
   cfg_space_port i_dut (.core_clk, .rst, .ce, .addr, .wdata, .byte_en, .wr_stb, .rd_stb,
      .rdata);
   cfg_host i_host (.core_clk, .addr, .wdata, .byte_en, .wr_stb, .rd_stb, .rdata);
   // ********
   // tests
   // ********
   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task blk(input logic cmd, input logic [6:0] n, input logic [7:0] r);
      i_host.send({24'h0, cmd, n}, 4'h1);
      i_host.send({24'h0, r}, 4'h1);
   endtask
   task t_reset;
      i_host.rd(`OFS_CONNECT_STATUS, v);
      chk(v, 32'h0);
      i_host.rd(`OFS_STATUS, v);
      chk(v, 32'h0);
      i_host.rd(8'h40, v);
      chk(v, 32'h0);
      $display("reset test done");
   endtask
   task t_write;
      i_host.conn(1'b1, v);
      chk(v, 32'h1);
      blk(`CMD_WRITE, `COUNT_ONE, `IREG_DUMMY);
      i_host.send(32'h00FF00FF, 4'hF);
      i_host.take(v);
      chk(v & 32'hFF, 32'h0);
      $display("write test done");
   endtask
   task t_read;
      blk(1'b0, `COUNT_ONE, `IREG_DUMMY);
      i_host.take(v);
      chk(v, 32'h00FF00FF);
      i_host.take(v);
      chk(v & 32'hFF, 32'h0);
      i_host.rd(`OFS_STATUS, v);
      chk(v, 32'h0);
      $display("read test done");
   endtask
   task t_error;
      blk(`CMD_WRITE, `COUNT_ONE, `IREG_BLOCKS);
      i_host.send(32'h5, 4'hF);
      i_host.take(v);
      chk(v & 32'hFF, {24'h0, `STATUS_FUNC_ERR});
      blk(1'b0, `COUNT_ONE, 8'h07);
      i_host.take(v);
      chk(v, 32'h0);
      i_host.take(v);
      chk(v & 32'hFF, {24'h0, `STATUS_FUNC_ERR});
      $display("error test done");
   endtask
   task t_regs;
      blk(`CMD_WRITE, `COUNT_ONE, `IREG_SCRATCH);
      i_host.send(32'hA5A5_1234, 4'h3);
      i_host.take(v);
      chk(v & 32'hFF, 32'h0);
      blk(`CMD_WRITE, 7'h00, `IREG_SCRATCH);
      i_host.take(v);
      chk(v & 32'hFF, 32'h0);
      blk(1'b0, 7'h02, `IREG_SCRATCH);
      repeat (2) begin
         i_host.take(v);
         chk(v, 32'h0000_1234);
      end
      i_host.take(v);
      chk(v & 32'hFF, 32'h0);
      // seven blocks completed before this one
      blk(1'b0, `COUNT_ONE, `IREG_BLOCKS);
      i_host.take(v);
      chk(v, 32'h0000_0007);
      i_host.take(v);
      chk(v & 32'hFF, 32'h0);
      $display("register test done");
   endtask
   task t_abort;
      blk(1'b0, `COUNT_ONE, `IREG_DUMMY);
      i_host.idle(6);
      i_host.wr(`OFS_CONNECT_CMD, 32'h0, 4'hF);
      i_host.idle(2);
      i_host.rd(`OFS_STATUS, v);
      chk(v, 32'h0);
      i_host.rd(`OFS_CONNECT_STATUS, v);
      chk(v, 32'h0);
      $display("abort test done");
   endtask
   task t_close;
      // a connect issued while the clock enable is low must be lost
      @(posedge core_clk);
      ce <= 1'b0;
      i_host.wr(`OFS_CONNECT_CMD, 32'h1, 4'hF);
      @(posedge core_clk);
      ce <= 1'b1;
      i_host.idle(3);
      i_host.rd(`OFS_CONNECT_STATUS, v);
      chk(v, 32'h0);
      i_host.conn(1'b1, v);
      chk(v, 32'h1);
      blk(1'b0, `COUNT_ONE, `IREG_DUMMY);
      i_host.take(v);
      chk(v, 32'h00FF00FF);
      i_host.take(v);
      chk(v & 32'hFF, 32'h0);
      i_host.conn(1'b0, v);
      chk(v, 32'h0);
      i_host.conn(1'b1, v);
      chk(v, 32'h1);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      i_host.rd(`OFS_CONNECT_STATUS, v);
      chk(v, 32'h0);
      i_host.rd(`OFS_STATUS, v);
      chk(v, 32'h0);
      $display("close test done");
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // cut a hang short well past the few hundred cycles needed
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_write();
      t_read();
      t_error();
      t_regs();
      t_abort();
      t_close();
      stop_test();
   end
endmodule // config_space_control_port_test
`default_nettype wire
